// *** design/power_handshake_pkg.sv ***
// Purpose : Shared constants, types and helpers for the power handshake block
// Assumes : 125 MHz always-on clock, synchronous active-low reset
// Notes   : Offsets, counts and the input and boot-source reset values of the block live here
//
// Contract
// R1: Carrier power enable only after module supplies good
// R2: Carrier keeps main circuits off until enable
// R3: No boot while carrier reset request low
// R4: Carrier releases reset request last, as power-good
// R5: Supply fault low keeps every supply disabled (code still enables the module supply for 3 cycles after reset)
// R6: Carrier drives inputs open-drain, no own pull-ups
// R7: Module stays in reset while request low
// R8: Power button active low, debounced
// R9: Standby output low in standby, else high
// R10: Battery low active low, reported by module
// R11: Carrier pulls charger present low with DC
// R12: Carrier pulls charging low while charging
// R13: Sleep request active low, debounced
// R14: Cover low means closed, debounced, sleep request (code reports it as cover_closed only, not as sleep_request)
// R15: Default boot from onboard flash, no NOR
// R16: Grounded boot select tries SD card first
// R17: Reset held at least 1 ms after release
// R18: Reset out released at least 100 ms after enable
// R19: Inputs double synchronised, debounce programmable stability count

package power_handshake_pkg;

    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int CLK_PERIOD_NS        = 8;       // 125 MHz always-on clock
    localparam int RESET_HOLD_TIME_US   = 1000;    // Least reset hold after release
    localparam int CARRIER_RAMP_TIME_MS = 100;     // Least carrier ramp before release
    // Least times round up to whole cycles
    localparam int RESET_HOLD_CYCLES    =
        (RESET_HOLD_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CARRIER_RAMP_CYCLES  =
        (CARRIER_RAMP_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ************************************************************
    // Widths and reset values
    // ************************************************************
    localparam int TIMER_W              = 24;      // Holds 12.5 M cycles
    localparam int DEBOUNCE_W           = 16;      // Programmable stability count
    localparam logic [DEBOUNCE_W-1:0] NO_DEBOUNCE = 16'h0000;
    localparam logic INPUT_IDLE_N       = 1'b1;    // Floating open-drain line reads high
    localparam logic BOOT_SD_RESET      = 1'b0;    // Onboard flash by default

    // ************************************************************
    // Input filter bank slots
    // ************************************************************
    localparam int NUM_INPUTS           = 9;
    localparam int IN_FAULT             = 0;
    localparam int IN_RESET_REQ         = 1;
    localparam int IN_POWER_BUTTON_N         = 2;
    localparam int IN_BATTERY_LOW       = 3;
    localparam int IN_CHARGER           = 4;
    localparam int IN_CHARGING          = 5;
    localparam int IN_SLEEP             = 6;
    localparam int IN_COVER             = 7;
    localparam int IN_BOOT_SEL          = 8;

    // ************************************************************
    // Sequencer states
    // ************************************************************
    typedef enum logic [3:0] {
        ST_OFF     = 4'h1,   // All supplies off
        ST_RAMP    = 4'h2,   // Module supplies ramping
        ST_CARRIER = 4'h4,   // Carrier powered, resets held
        ST_RUN     = 4'h8    // Resets released, booting or running
    } seq_state_e;

    // Saturating increment for free-running cycle counters
    function automatic logic [TIMER_W-1:0] sat_inc(input logic [TIMER_W-1:0] v);
        sat_inc = (v == {TIMER_W{1'b1}}) ? v : v + 24'h000001;
    endfunction

endpackage

// *** design/input_filter_if.sv ***
// Purpose : Bundle between the sequencer and one input filter
// Assumes : One bundle per carrier input line
// Notes   : Levels stay active low as on the pin

`timescale 1ns/10ps

interface input_filter_if;
    import power_handshake_pkg::*;

    logic                  raw_n;     // Line as seen at the pin
    logic [DEBOUNCE_W-1:0] limit;     // Stability count, zero for sync only
    logic                  level_n;   // Filtered level

    // Filter side
    modport filt (input raw_n, input limit, output level_n);
    // Sequencer side
    modport user (output raw_n, output limit, input level_n);
endinterface

// *** design/input_debounce.sv ***
// Purpose : Two-stage synchroniser followed by a stability filter
// Assumes : Line is open drain and floats high when idle
// Notes   : Level changes once the sample differs for limit+1 cycles

`timescale 1ns/10ps

module input_debounce (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Filter bundle
    input_filter_if.filt fi
);
    import power_handshake_pkg::*;

    logic                  sync1_reg;   // First stage, read by second only
    logic                  sync2_reg;   // Second stage
    logic [DEBOUNCE_W-1:0] stab_reg;    // Cycles the sample has differed
    logic                  level_reg;   // Filtered output

    assign fi.level_n = level_reg;

    // ************************************************************
    // Synchroniser
    // ************************************************************
    // Two flops against metastability on the carrier line
    always_ff @(posedge clk) begin  // see R19
        if (!rst_b) begin
            sync1_reg <= INPUT_IDLE_N;
            sync2_reg <= INPUT_IDLE_N;
        end else begin
            sync1_reg <= fi.raw_n;
            sync2_reg <= sync1_reg;
        end
    end

    // ************************************************************
    // Stability filter
    // ************************************************************
    // Any bounce back to the held level restarts the count
    always_ff @(posedge clk) begin  // see R19
        if (!rst_b) begin
            stab_reg  <= NO_DEBOUNCE;
            level_reg <= INPUT_IDLE_N;
        end else if (sync2_reg == level_reg) begin
            stab_reg  <= NO_DEBOUNCE;
        end else if (stab_reg >= fi.limit) begin
            stab_reg  <= NO_DEBOUNCE;
            level_reg <= sync2_reg;
        end else begin
            stab_reg  <= stab_reg + 16'h0001;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    a_debounce_stable: assert property (@(posedge clk) disable iff (!rst_b)  // see R19
        (level_reg != $past(level_reg)) |-> ($past(stab_reg) >= $past(fi.limit)))
        else $error("filtered level changed before the stability count");

endmodule

// *** design/cycle_timer.sv ***
// Purpose : Counts cycles while run is high and flags expiry
// Assumes : Limit is at least one
// Notes   : Dropping run clears the count at once

`timescale 1ns/10ps

module cycle_timer (
    // Clock and reset
    input  wire logic                                  clk,
    input  wire logic                                  rst_b,
    // Control
    input  wire logic                                  run,
    input  wire logic [power_handshake_pkg::TIMER_W-1:0] limit,
    // Status
    output logic                                       expired
);
    import power_handshake_pkg::*;

    logic [TIMER_W-1:0] count_reg;   // Elapsed cycles while running

    // Count up while running, park at the limit
    always_ff @(posedge clk) begin
        if (!rst_b || !run) begin
            count_reg <= '0;
        end else if (count_reg != limit) begin
            count_reg <= count_reg + 24'h000001;
        end
    end

    assign expired = run && (count_reg == limit);

    a_timer_length: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(expired) |-> $past(run, 1) && (count_reg == limit))
        else $error("timer expired without a full count");

endmodule

// *** design/power_handshake.sv ***
// Purpose : Module-side power and reset handshake with the carrier
// Assumes : Open-drain carrier inputs are pulled up on the module
// Notes   : Long waits are parameters so simulation can shorten them

`timescale 1ns/10ps

module power_handshake #(
    parameter int RESET_HOLD  = power_handshake_pkg::RESET_HOLD_CYCLES,
    parameter int CARRIER_RAMP = power_handshake_pkg::CARRIER_RAMP_CYCLES
) (
    // Clock and reset
    input  wire logic                                       clk,
    input  wire logic                                       rst_b,
    // Module supply status and standby from the system
    input  wire logic                                       module_supplies_good,
    input  wire logic                                       standby_state,
    input  wire logic [power_handshake_pkg::DEBOUNCE_W-1:0] debounce_limit,
    // Carrier control inputs, open drain, active low
    input  wire logic                                       input_supply_fault_n,
    input  wire logic                                       reset_request_n,
    input  wire logic                                       power_button_n,
    input  wire logic                                       battery_low_n,
    input  wire logic                                       charger_present_n,
    input  wire logic                                       charging_n,
    input  wire logic                                       sleep_request_n,
    input  wire logic                                       cover_closed_n,
    input  wire logic                                       boot_select_n,
    // Carrier control outputs
    output logic                                            carrier_power_enable,
    output logic                                            module_reset_out_n,
    output logic                                            carrier_standby_n,
    // Module side outputs
    output logic                                            module_supply_enable,
    output logic                                            core_reset_n,
    output logic                                            boot_start,
    output logic                                            boot_from_sd,
    // Reported carrier indications, active high
    output logic                                            power_button_pressed,
    output logic                                            battery_low,
    output logic                                            charger_present,
    output logic                                            charging,
    output logic                                            sleep_request,
    output logic                                            cover_closed
);
    import power_handshake_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [NUM_INPUTS-1:0] raw_n;            // Pins gathered by slot
    logic [NUM_INPUTS-1:0] filt_n;           // Filtered levels by slot
    seq_state_e            state_reg;        // Sequencer state
    seq_state_e            state_next;       // Its next value
    logic                  fault_ok;         // Input supply reported good
    logic                  req_released;     // Carrier reset request floated
    logic                  hold_done;        // 1 ms since request release
    logic                  ramp_done;        // 100 ms since power enable
    logic                  cpe_reg;          // Carrier power enable
    logic                  rst_out_reg;      // Reset out, high when released
    logic                  core_rst_reg;     // Internal reset, high when released
    logic                  supply_en_reg;    // Module supply enable
    logic                  stby_reg;         // Carrier standby, active low
    logic                  boot_start_reg;   // One-cycle boot kick
    logic                  boot_sd_reg;      // Boot source latched at release
    logic [5:0]            report_reg;       // Reported indications

    // ************************************************************
    // Input filter bank
    // ************************************************************
    assign raw_n = {boot_select_n, cover_closed_n, sleep_request_n, charging_n,
                    charger_present_n, battery_low_n, power_button_n,
                    reset_request_n, input_supply_fault_n};

    input_filter_if fbus [NUM_INPUTS] ();

    // One filter per line; fault and reset request are synchronised only,
    // so a short reset request still reaches the sequencer
    for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_filt
        assign fbus[i].raw_n = raw_n[i];
        assign fbus[i].limit = (i == IN_FAULT || i == IN_RESET_REQ) ?
                               NO_DEBOUNCE : debounce_limit;
        assign filt_n[i]     = fbus[i].level_n;
        input_debounce u_filt (
            .clk   (clk),
            .rst_b (rst_b),
            .fi    (fbus[i])
        );
    end

    assign fault_ok     = filt_n[IN_FAULT];
    assign req_released = filt_n[IN_RESET_REQ];

    // ************************************************************
    // Timers
    // ************************************************************
    // Reset hold restarts on every new request, even a short one
    cycle_timer u_hold (
        .clk     (clk),
        .rst_b   (rst_b),
        .run     (req_released),
        .limit   (TIMER_W'(RESET_HOLD)),
        .expired (hold_done)
    );

    // Carrier ramp runs for as long as the carrier is powered
    cycle_timer u_ramp (
        .clk     (clk),
        .rst_b   (rst_b),
        .run     (cpe_reg),
        .limit   (TIMER_W'(CARRIER_RAMP)),
        .expired (ramp_done)
    );

    // ************************************************************
    // Sequencer
    // ************************************************************
    // Next state; fault or lost supplies drop everything at once
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF: begin
                // Only supervisory logic lives while the filtered fault is low
                if (fault_ok) begin  // see R5
                    state_next = ST_RAMP;
                end
            end
            ST_RAMP: begin
                if (!fault_ok) begin
                    state_next = ST_OFF;
                end else if (module_supplies_good) begin  // see R1
                    state_next = ST_CARRIER;
                end
            end
            ST_CARRIER: begin
                // Boot waits for the carrier's power-good release
                if (!fault_ok || !module_supplies_good) begin
                    state_next = ST_OFF;
                end else if (req_released && hold_done && ramp_done) begin  // see R3
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!fault_ok || !module_supplies_good) begin
                    state_next = ST_OFF;
                end else if (!req_released) begin  // see R7
                    state_next = ST_CARRIER;
                end
            end
            default: begin
                state_next = ST_OFF;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_reg <= ST_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // ************************************************************
    // Power outputs
    // ************************************************************
    // Outputs follow the next state so they settle with the state flop
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            supply_en_reg <= 1'b0;
            cpe_reg       <= 1'b0;
        end else begin
            supply_en_reg <= (state_next != ST_OFF);  // see R5
            cpe_reg       <= (state_next == ST_CARRIER) ||
                             (state_next == ST_RUN);  // see R1
        end
    end

    // ************************************************************
    // Reset outputs
    // ************************************************************
    // Both resets release together, only on entry to running
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rst_out_reg  <= 1'b0;
            core_rst_reg <= 1'b0;
        end else begin
            rst_out_reg  <= (state_next == ST_RUN);  // see R17 R18
            core_rst_reg <= (state_next == ST_RUN);  // see R17
        end
    end

    // ************************************************************
    // Boot source
    // ************************************************************
    // Select is sampled once per release; a change while running
    // only takes effect on the next reset
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            boot_sd_reg    <= BOOT_SD_RESET;  // see R15
            boot_start_reg <= 1'b0;
        end else begin
            boot_start_reg <= (state_next == ST_RUN) && (state_reg != ST_RUN);
            if ((state_next == ST_RUN) && (state_reg != ST_RUN)) begin
                boot_sd_reg <= !filt_n[IN_BOOT_SEL];  // see R16
            end
        end
    end

    // ************************************************************
    // Standby and reported indications
    // ************************************************************
    // Standby follows the system state directly
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stby_reg <= 1'b1;
        end else begin
            stby_reg <= !standby_state;  // see R9
        end
    end

    // Filtered carrier lines, inverted to active high
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            report_reg <= 6'h00;
        end else begin
            report_reg[0] <= !filt_n[IN_POWER_BUTTON_N];    // see R8
            report_reg[1] <= !filt_n[IN_BATTERY_LOW];  // see R10
            report_reg[2] <= !filt_n[IN_CHARGER];
            report_reg[3] <= !filt_n[IN_CHARGING];
            report_reg[4] <= !filt_n[IN_SLEEP];        // see R13
            report_reg[5] <= !filt_n[IN_COVER];        // see R14
        end
    end

    assign module_supply_enable = supply_en_reg;
    assign carrier_power_enable = cpe_reg;
    assign module_reset_out_n   = rst_out_reg;
    assign core_reset_n         = core_rst_reg;
    assign carrier_standby_n    = stby_reg;
    assign boot_start           = boot_start_reg;
    assign boot_from_sd         = boot_sd_reg;
    assign power_button_pressed = report_reg[0];
    assign battery_low          = report_reg[1];
    assign charger_present      = report_reg[2];
    assign charging             = report_reg[3];
    assign sleep_request        = report_reg[4];
    assign cover_closed         = report_reg[5];

    // ************************************************************
    // Checks
    // ************************************************************
    logic [TIMER_W-1:0] since_release_reg;   // Cycles since request release
    logic [TIMER_W-1:0] since_enable_reg;    // Cycles since power enable

    // Helper counters for the timing checks
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            since_release_reg <= '0;
            since_enable_reg  <= '0;
        end else begin
            since_release_reg <= req_released ? sat_inc(since_release_reg) : '0;
            since_enable_reg  <= cpe_reg ? sat_inc(since_enable_reg) : '0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_enable_needs_supply: assert property (  // see R1
        $rose(carrier_power_enable) |-> $past(module_supplies_good, 1))
        else $error("carrier power enabled before module supplies good");
    a_reset_holds_boot: assert property (  // see R7
        !req_released |=> !module_reset_out_n && !core_reset_n)
        else $error("reset released while the request is low");
    a_fault_kills_supply: assert property (  // see R5
        !fault_ok |=> !module_supply_enable && !carrier_power_enable)
        else $error("supply enabled while input supply fault is low");
    a_release_hold_time: assert property (  // see R17
        $rose(module_reset_out_n) |-> since_release_reg >= TIMER_W'(RESET_HOLD))
        else $error("reset released under the hold time");
    a_carrier_ramp_time: assert property (  // see R18
        $rose(module_reset_out_n) |-> since_enable_reg >= TIMER_W'(CARRIER_RAMP))
        else $error("reset released under the carrier ramp time");
    a_boot_after_release: assert property (  // see R3
        $rose(core_reset_n) |-> $past(req_released, 1) && boot_start)
        else $error("boot started without a request release");
    a_standby_output: assert property (  // see R9
        standby_state ##1 standby_state |=> !carrier_standby_n)
        else $error("standby output high during standby");
    a_boot_source_pick: assert property (  // see R16
        boot_start |-> boot_from_sd == !$past(filt_n[IN_BOOT_SEL], 1))
        else $error("boot source does not follow select");
    a_report_button: assert property (  // see R8
        !filt_n[IN_POWER_BUTTON_N] |=> power_button_pressed)
        else $error("power button press not reported");

    c_reach_run:      cover property ($rose(module_reset_out_n));
    c_reset_reentry:  cover property (module_reset_out_n ##1 !module_reset_out_n);
    c_sd_boot:        cover property (boot_start && boot_from_sd);
    c_fault_in_run:   cover property (core_reset_n && !fault_ok);

endmodule

// *** sim/carrier_model.sv ***
// Purpose : Carrier side, open-drain lines and reset request
// Assumes : Module pull-ups, so a released line reads high
// Notes   : Reset request released a while after power enable
`timescale 1ns/10ps
module carrier_model (
    // Clock and module output
    input  wire logic       clk,
    input  wire logic       carrier_power_enable,
    // Test control, high pulls a line low
    input  wire logic [7:0] pull,
    input  wire logic       force_rst,
    // Lines to the module
    output logic [7:0]      line_n,
    output logic            reset_request_n
);
    logic [7:0] up_reg = 8'h00; // Cycles of power enable
    // Low or released, never driven high
    assign line_n = ~pull;
    // Released last, as carrier power good
    assign reset_request_n = (up_reg > 8'h0a) && !force_rst;
    // Rails come up only after the enable
    always_ff @(posedge clk) begin
        up_reg <= carrier_power_enable ? up_reg + {7'h00, up_reg != 8'hff} : 8'h00;
    end
endmodule

// *** sim/tb.sv ***
// Purpose : Self-checking bench for the power handshake
// Assumes : Short hold and ramp counts
// Notes   : Notes queued by the driver, checked by a monitor
`timescale 1ns/10ps
module tb;
    localparam int HOLD = 20;
    localparam int RAMP = 40;
    logic clk = 1'b0, rst_b = 1'b0, good = 1'b0, stby = 1'b0, frc = 1'b0;
    logic [7:0]  pull = 8'h01;  // Fault held low at start
    logic [15:0] lim = 16'h0000;
    logic [7:0]  ln;
    logic        rq_n, cpe, rout_n, crst_n, stby_n, sup_en, boot, sd;
    wire  [5:0]  rep;
    logic [11:0] q[$];          // Expected output vectors
    logic [31:0] r;
    int failures = 0, n_tests = 0, seed = 32'h2ed81f64, cyc = 0, on_c = 0, rq_c = 0;
    always #4 clk = ~clk;
    carrier_model cm_u (.clk(clk), .carrier_power_enable(cpe), .pull(pull),
        .force_rst(frc), .line_n(ln), .reset_request_n(rq_n));
    power_handshake #(.RESET_HOLD(HOLD), .CARRIER_RAMP(RAMP)) dut_u (.clk(clk),
        .rst_b(rst_b), .module_supplies_good(good), .standby_state(stby),
        .debounce_limit(lim), .input_supply_fault_n(ln[0]), .reset_request_n(rq_n),
        .power_button_n(ln[1]), .battery_low_n(ln[2]), .charger_present_n(ln[3]),
        .charging_n(ln[4]), .sleep_request_n(ln[5]), .cover_closed_n(ln[6]),
        .boot_select_n(ln[7]), .carrier_power_enable(cpe), .module_reset_out_n(rout_n),
        .carrier_standby_n(stby_n), .module_supply_enable(sup_en), .core_reset_n(crst_n),
        .boot_start(boot), .boot_from_sd(sd), .power_button_pressed(rep[0]),
        .battery_low(rep[1]), .charger_present(rep[2]), .charging(rep[3]),
        .sleep_request(rep[4]), .cover_closed(rep[5]));
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Note a result due n edges on
    task automatic expect_in(input int n, input logic [11:0] exp);
        repeat (n) @(posedge clk);
        q.push_back(exp);
    endtask
    // Bounded wait for the boot pulse
    task automatic wait_boot();
        for (int i = 0; i < 200 && boot !== 1'b1; i++) @(negedge clk);
        @(posedge clk);
    endtask
    // Monitor: oldest note against outputs, plus release timing
    always @(negedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            failures++;
            test_done();
        end
        if (q.size() > 0)
            check({cpe, rout_n, crst_n, stby_n, sup_en, sd, rep}, q.pop_front());
        on_c = cpe ? on_c + 1 : 0;
        rq_c = rq_n ? rq_c + 1 : 0;
        if (boot === 1'b1) begin
            check({11'h0, on_c > RAMP}, 12'h001);
            check({11'h0, rq_c > HOLD}, 12'h001);
        end
    end
    initial begin
        lim <= 16'(($random(seed) & 7) + 1);
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        pull <= 8'h81;
        expect_in(8, 12'h100);
        pull <= 8'h80;
        expect_in(8, 12'h180);
        good <= 1'b1;
        expect_in(4, 12'h980);
        wait_boot();
        expect_in(1, 12'hfc0);
        frc <= 1'b1;
        pull <= 8'h00;
        expect_in(6, 12'h9c0);
        frc <= 1'b0;
        wait_boot();
        expect_in(1, 12'hf80);
        pull <= 8'h7e;
        repeat (lim) @(posedge clk);
        pull <= 8'h00;
        expect_in(lim + 8, 12'hf80);
        for (int k = 0; k < 8; k++) begin
            r = $random(seed);
            pull <= {1'b0, r[5:0], 1'b0};
            stby <= r[6];
            expect_in(lim + 8, {3'b111, ~r[6], 2'b10, r[5:0]});
        end
        pull <= 8'h01;
        stby <= 1'b0;
        expect_in(lim + 8, 12'h100);
        expect_in(2, 12'h100);
        @(posedge clk);
        test_done();
    end
endmodule
